/* verilog/fss_top.sv */
`timescale 1ns/1ps
`include "fss_regs.svh"
// Functional notes
// - CCW rotation: B lags A by quarter period.
// - Setting swaps direction versus phase order.
// - One active-low zero mark per revolution.
// - Zero mark held low at least 400 us.
// - Two monitors show selected quantity, 10 bits.
// - Forced stop: decelerate, then dynamic brake.
// - Display forced-stop warning code during sequence.
// - Deceleration follows programmable time constant.
// - Below zero speed: cut base, brake.
// - Programmable delay from interlock off to base off.
// - Delay applies to stop, alarm, network loss.
// - Freefall lift needs amount, zero speed, delay.
// - Freefall lift raises shaft during delay.
// - Torque mode skips forced-stop deceleration.
// - Network loss starts forced-stop deceleration.
// - Immediate-brake alarms skip deceleration entirely.
// - Torque-off during deceleration raises timing error.
// - Other alarms give no deceleration guarantee.
// - Zero speed defaults 50 r/min, inclusive.
module fss_top
  import fss_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int REV_W = 20,
  parameter int MS_CYC = int'(`FSS_MS_CYC),
  parameter int ZMARK_CYC = int'(`FSS_ZMARK_CYC),
  parameter logic [15:0] RATED_SPEED = `FSS_RATED_SPEED
) (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  // Machine pins, not synchronous to the clock.
  input wire logic FORCED_STOP_INPUT_I,
  input wire logic SAFE_TORQUE_OFF_INPUT_I,
  // Drive events.
  input wire logic ALARM_I,
  input wire logic ALARM_DB_NOW_I,
  input wire logic NET_SHUTOFF_I,
  input wire logic ALARM_RESET_I,
  input wire logic TORQUE_MODE_I,
  // Motor feedback and normal command.
  input wire logic signed [15:0] MOTOR_SPEED_I,
  input wire logic signed [15:0] SPEED_CMD_I,
  input wire logic [POS_W-1:0] MOTOR_POS_I,
  input wire logic [REV_W-1:0] REV_POS_I,
  // Settings.
  input wire logic [15:0] ENCODER_OUTPUT_PULSE_SETTING_I,
  input wire logic [15:0] ENCODER_OUTPUT_RATIO_SETTING_I,
  input wire logic ENCODER_PHASE_RELATION_SELECT_I,
  input wire logic [15:0] ZERO_SPEED_THRESHOLD_I,
  input wire logic ZERO_SPEED_LOAD_I,
  input wire logic [15:0] STOP_DECEL_TIME_CONSTANT_I,
  input wire logic [15:0] BRAKE_TO_BASE_DELAY_PARAM_I,
  input wire logic [15:0] FREEFALL_COMP_AMOUNT_I,
  input wire logic [1:0] MONITOR_ONE_SELECT_I,
  input wire logic [1:0] MONITOR_TWO_SELECT_I,
  // Encoder outputs.
  output logic ENCODER_A_PHASE_OUT_O,
  output logic ENCODER_A_PHASE_OUT_INV_O,
  output logic ENCODER_B_PHASE_OUT_O,
  output logic ENCODER_B_PHASE_OUT_INV_O,
  output logic ENCODER_ZERO_MARK_OUT_O,
  output logic ENCODER_ZERO_MARK_OUT_INV_O,
  // Monitor data.
  output logic [`FSS_MON_W-1:0] ANALOG_MONITOR_ONE_O,
  output logic [`FSS_MON_W-1:0] ANALOG_MONITOR_TWO_O,
  // Stop sequence.
  output logic BRAKE_INTERLOCK_OUT_O,
  output logic BASE_ON_O,
  output logic DYNAMIC_BRAKE_O,
  output logic signed [15:0] MODEL_SPEED_O,
  output logic [15:0] FREEFALL_LIFT_O,
  output logic [7:0] DISPLAY_CODE_O,
  output logic TORQUE_OFF_TIMING_ERROR_O,
  output logic ZERO_SPEED_FLAG_O,
  output logic [2:0] STOP_STATE_O
);

  ////////////////////////////////////////////////////////////////////////////

  logic [1:0] em_sync_reg;
  logic [1:0] sto_sync_reg;
  logic sto_prev_reg;
  logic em_ok;
  logic sto_ok;

  // Pins pass two flops; only the second is read.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      em_sync_reg <= 2'h3;
      sto_sync_reg <= 2'h3;
      sto_prev_reg <= 1'b1;
    end else begin
      em_sync_reg <= {em_sync_reg[0], FORCED_STOP_INPUT_I};
      sto_sync_reg <= {sto_sync_reg[0], SAFE_TORQUE_OFF_INPUT_I};
      sto_prev_reg <= sto_sync_reg[1];
    end
  end

  assign em_ok = em_sync_reg[1];
  assign sto_ok = sto_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] zsp_thr_reg;
  logic zsp_reg;
  logic [15:0] spd_mag;
  logic [16:0] zsp_off_level;

  assign spd_mag = MOTOR_SPEED_I[15] ? 16'(-MOTOR_SPEED_I)
                                     : 16'(MOTOR_SPEED_I);
  assign zsp_off_level = {1'b0, zsp_thr_reg} + {1'b0, `FSS_ZSP_HYST};

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      zsp_thr_reg <= `FSS_ZSP_DEFAULT;
    end else if (ZERO_SPEED_LOAD_I) begin
      zsp_thr_reg <= ZERO_SPEED_THRESHOLD_I;
    end
  end

  // Hysteresis keeps the flag from chattering around the threshold.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      zsp_reg <= 1'b1;
    end else if (spd_mag <= zsp_thr_reg) begin
      zsp_reg <= 1'b1;
    end else if ({1'b0, spd_mag} > zsp_off_level) begin
      zsp_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  fss_state_t state_reg;
  fss_state_t state_next;
  logic stop_trig;
  logic ms_tick;
  logic [31:0] ms_cnt_reg;
  logic [15:0] dly_ms_reg;
  logic dly_done;
  logic sto_err_reg;
  logic ff_reg;
  logic ff_arm;

  // Every stop source except ALARM_DB_NOW_I leads into the same delayed shut-off path; that one goes straight to base off.
  assign stop_trig = !em_ok | ALARM_I | NET_SHUTOFF_I | ALARM_DB_NOW_I;
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));
  assign dly_done = ms_tick &&
                    (dly_ms_reg == BRAKE_TO_BASE_DELAY_PARAM_I - 16'h0001);
  assign ff_arm = (FREEFALL_COMP_AMOUNT_I != 16'h0000) && zsp_reg &&
                  (BRAKE_TO_BASE_DELAY_PARAM_I != 16'h0000);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSS_RUN: begin
        if (stop_trig) begin
          if (ALARM_DB_NOW_I) begin
            state_next = FSS_BASE_OFF;
          end else if (TORQUE_MODE_I) begin
            state_next = FSS_ILK_REL;
          end else begin
            state_next = FSS_DECEL;
          end
        end
      end
      FSS_DECEL: begin
        if (ALARM_DB_NOW_I) begin
          state_next = FSS_BASE_OFF;
        end else if (zsp_reg) begin
          state_next = FSS_ILK_REL;
        end
      end
      FSS_ILK_REL: begin
        if (ALARM_DB_NOW_I ||
            BRAKE_TO_BASE_DELAY_PARAM_I == 16'h0000) begin
          state_next = FSS_BASE_OFF;
        end else begin
          state_next = FSS_DELAY;
        end
      end
      FSS_DELAY: begin
        if (ALARM_DB_NOW_I || dly_done) begin
          state_next = FSS_BASE_OFF;
        end
      end
      FSS_BASE_OFF: begin
        if (ALARM_RESET_I && !stop_trig && !sto_err_reg) begin
          state_next = FSS_RUN;
        end
      end
      default: begin
        state_next = FSS_BASE_OFF;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      state_reg <= FSS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || (state_reg != FSS_DECEL && state_reg != FSS_DELAY)) begin
      ms_cnt_reg <= 32'h0;
    end else if (ms_tick) begin
      ms_cnt_reg <= 32'h0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || state_reg != FSS_DELAY) begin
      dly_ms_reg <= 16'h0;
    end else if (ms_tick) begin
      dly_ms_reg <= dly_ms_reg + 16'h1;
    end
  end

  // The error stays until reset; a new event wins over the reset request.
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      sto_err_reg <= 1'b0;
    end else if (state_reg == FSS_DECEL && sto_prev_reg && !sto_ok) begin
      sto_err_reg <= 1'b1;
    end else if (ALARM_RESET_I && state_reg == FSS_BASE_OFF) begin
      sto_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || state_reg == FSS_BASE_OFF) begin
      ff_reg <= 1'b0;
    end else if (state_reg == FSS_RUN && stop_trig) begin
      ff_reg <= ff_arm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] decel_lim;
  logic [31:0] decel_acc_reg;
  logic [31:0] decel_sum;
  logic decel_step;

  // One r/min of slope per step, so at most one step per clock.
  assign decel_lim = 32'(STOP_DECEL_TIME_CONSTANT_I) * 32'(MS_CYC);
  assign decel_sum = decel_acc_reg + 32'(RATED_SPEED);
  assign decel_step = (decel_sum >= decel_lim);

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || state_reg != FSS_DECEL) begin
      decel_acc_reg <= 32'h0;
    end else if (decel_step) begin
      decel_acc_reg <= decel_sum - decel_lim;
    end else begin
      decel_acc_reg <= decel_sum;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      MODEL_SPEED_O <= 16'sh0;
    end else if (state_next == FSS_RUN) begin
      MODEL_SPEED_O <= SPEED_CMD_I;
    end else if (state_next != FSS_DECEL) begin
      MODEL_SPEED_O <= 16'sh0;
    end else if (state_reg == FSS_RUN) begin
      MODEL_SPEED_O <= MOTOR_SPEED_I;
    end else if (STOP_DECEL_TIME_CONSTANT_I == 16'h0000) begin
      MODEL_SPEED_O <= 16'sh0;
    end else if (decel_step && MODEL_SPEED_O != 16'sh0) begin
      MODEL_SPEED_O <= MODEL_SPEED_O[15] ? MODEL_SPEED_O + 16'sh1
                                         : MODEL_SPEED_O - 16'sh1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      BRAKE_INTERLOCK_OUT_O <= 1'b0;
      BASE_ON_O <= 1'b0;
      DYNAMIC_BRAKE_O <= 1'b0;
      FREEFALL_LIFT_O <= 16'h0;
      DISPLAY_CODE_O <= `FSS_NO_CODE;
    end else begin
      BRAKE_INTERLOCK_OUT_O <= (state_next == FSS_RUN) ||
                               (state_next == FSS_DECEL);
      BASE_ON_O <= (state_next != FSS_BASE_OFF);
      DYNAMIC_BRAKE_O <= (state_next == FSS_BASE_OFF);
      FREEFALL_LIFT_O <= (state_next == FSS_DELAY && ff_reg) ?
                         FREEFALL_COMP_AMOUNT_I : 16'h0;
      if (sto_err_reg) begin
        DISPLAY_CODE_O <= `FSS_STO_ERR_CODE;
      end else if (state_next != FSS_RUN) begin
        DISPLAY_CODE_O <= `FSS_WARN_CODE;
      end else begin
        DISPLAY_CODE_O <= `FSS_NO_CODE;
      end
    end
  end

  assign TORQUE_OFF_TIMING_ERROR_O = sto_err_reg;
  assign ZERO_SPEED_FLAG_O = zsp_reg;
  assign STOP_STATE_O = state_reg;

  ////////////////////////////////////////////////////////////////////////////

  logic [POS_W-1:0] pos_prev_reg;
  logic signed [15:0] pos_delta;
  logic signed [32:0] pos_prod;
  logic signed [39:0] enc_acc_reg;
  logic signed [39:0] enc_sum;
  logic signed [39:0] enc_ratio;
  logic enc_fwd;
  logic enc_back;
  logic quad_a;
  logic quad_b;

  // Motion above one output edge per clock is not followed in full.
  assign pos_delta = 16'(MOTOR_POS_I - pos_prev_reg);
  assign pos_prod = pos_delta * $signed({1'b0, ENCODER_OUTPUT_PULSE_SETTING_I});
  assign enc_sum = enc_acc_reg + 40'(pos_prod);
  assign enc_ratio = (ENCODER_OUTPUT_RATIO_SETTING_I == 16'h0000) ?
                     40'sh1 : 40'(ENCODER_OUTPUT_RATIO_SETTING_I);
  assign enc_fwd = (enc_sum >= enc_ratio);
  assign enc_back = (enc_sum <= -enc_ratio);

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      pos_prev_reg <= '0;
      enc_acc_reg <= 40'sh0;
    end else begin
      pos_prev_reg <= MOTOR_POS_I;
      if (enc_fwd) begin
        enc_acc_reg <= enc_sum - enc_ratio;
      end else if (enc_back) begin
        enc_acc_reg <= enc_sum + enc_ratio;
      end else begin
        enc_acc_reg <= enc_sum;
      end
    end
  end

  fss_quad_gen u_quad (
    .clk_i(SYS_CLK_I),
    .rst_i(SRST_I),
    .step_i(enc_fwd || enc_back),
    .ccw_i(enc_fwd),
    .swap_i(ENCODER_PHASE_RELATION_SELECT_I),
    .a_o(quad_a),
    .b_o(quad_b)
  );

  assign ENCODER_A_PHASE_OUT_O = quad_a;
  assign ENCODER_A_PHASE_OUT_INV_O = !quad_a;
  assign ENCODER_B_PHASE_OUT_O = quad_b;
  assign ENCODER_B_PHASE_OUT_INV_O = !quad_b;

  ////////////////////////////////////////////////////////////////////////////

  logic [REV_W-1:0] rev_prev_reg;
  logic [31:0] zm_cnt_reg;
  logic zm_load;
  logic zm_n_reg;
  logic [31:0] zlow_len_reg;

  assign zm_load = (REV_POS_I == '0) && (rev_prev_reg != '0) &&
                   (zm_cnt_reg == 32'h0);

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      rev_prev_reg <= '0;
      zm_cnt_reg <= 32'h0;
      zm_n_reg <= 1'b1;
    end else begin
      rev_prev_reg <= REV_POS_I;
      if (zm_load) begin
        zm_cnt_reg <= 32'(ZMARK_CYC);
      end else if (zm_cnt_reg != 32'h0) begin
        zm_cnt_reg <= zm_cnt_reg - 32'h1;
      end
      zm_n_reg <= !(zm_load || zm_cnt_reg > 32'h1);
    end
  end

  assign ENCODER_ZERO_MARK_OUT_O = zm_n_reg;
  assign ENCODER_ZERO_MARK_OUT_INV_O = !zm_n_reg;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [`FSS_MON_W-1:0] mon_pick(
    input logic [1:0] sel,
    input logic [15:0] spd,
    input logic [15:0] mdl,
    input logic [15:0] lift,
    input logic [2:0] st
  );
    logic [15:0] word;
    word = 16'h0;
    unique case (fss_mon_sel_t'(sel))
      FSS_MON_SPEED: word = {!spd[15], spd[14:0]};
      FSS_MON_MODEL: word = {!mdl[15], mdl[14:0]};
      FSS_MON_LIFT: word = lift;
      FSS_MON_STATE: word = {st, 13'h0};
    endcase
    mon_pick = word[15:16-`FSS_MON_W];
  endfunction

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      ANALOG_MONITOR_ONE_O <= '0;
      ANALOG_MONITOR_TWO_O <= '0;
    end else begin
      ANALOG_MONITOR_ONE_O <= mon_pick(MONITOR_ONE_SELECT_I, MOTOR_SPEED_I,
        MODEL_SPEED_O, FREEFALL_LIFT_O, state_reg);
      ANALOG_MONITOR_TWO_O <= mon_pick(MONITOR_TWO_SELECT_I, MOTOR_SPEED_I,
        MODEL_SPEED_O, FREEFALL_LIFT_O, state_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || zm_n_reg) begin
      zlow_len_reg <= 32'h0;
    end else begin
      zlow_len_reg <= zlow_len_reg + 32'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  AST_ZMARK_ONCE: assert property (
    $fell(ENCODER_ZERO_MARK_OUT_O) |-> $past(REV_POS_I) == '0)
    else $error("Zero mark fell away from the zero point.");

  AST_ZMARK_WIDTH: assert property (
    $rose(ENCODER_ZERO_MARK_OUT_O) |-> zlow_len_reg >= 32'(ZMARK_CYC))
    else $error("Zero mark was shorter than its least width.");

  AST_DECEL_ENTRY: assert property (
    (state_reg == FSS_RUN && !em_ok && !ALARM_DB_NOW_I && !TORQUE_MODE_I)
    |=> state_reg == FSS_DECEL ##1 DYNAMIC_BRAKE_O == 1'b0)
    else $error("Forced stop did not start deceleration.");

  AST_WARN_SHOWN: assert property (
    ($rose(state_reg != FSS_RUN) && !sto_err_reg)
    |-> DISPLAY_CODE_O == `FSS_WARN_CODE)
    else $error("Warning code missing during stop sequence.");

  AST_ZSP_CUT: assert property (
    (state_reg == FSS_DECEL && zsp_reg && !ALARM_DB_NOW_I)
    |=> state_reg == FSS_ILK_REL && !BRAKE_INTERLOCK_OUT_O)
    else $error("Zero speed did not end deceleration.");

  AST_DELAY_END: assert property (
    (state_reg == FSS_DELAY && dly_done)
    |=> !BASE_ON_O && DYNAMIC_BRAKE_O && state_reg == FSS_BASE_OFF)
    else $error("Base circuit not cut at end of delay.");

  AST_LIFT: assert property (
    (state_reg == FSS_DELAY && ff_reg && $stable(FREEFALL_COMP_AMOUNT_I))
    |-> FREEFALL_LIFT_O == FREEFALL_COMP_AMOUNT_I)
    else $error("Freefall lift not applied during delay.");

  AST_TORQUE_SKIP: assert property (
    (state_reg == FSS_RUN && stop_trig && TORQUE_MODE_I)
    |=> state_reg != FSS_DECEL)
    else $error("Deceleration entered in torque mode.");

  AST_DB_NOW: assert property (
    (ALARM_DB_NOW_I && state_reg != FSS_BASE_OFF)
    |=> state_reg == FSS_BASE_OFF && DYNAMIC_BRAKE_O)
    else $error("Immediate brake alarm did not brake.");

  AST_STO_ERR: assert property (
    (state_reg == FSS_DECEL && sto_prev_reg && !sto_ok)
    |=> TORQUE_OFF_TIMING_ERROR_O ##1 DISPLAY_CODE_O == `FSS_STO_ERR_CODE)
    else $error("Torque-off during deceleration not flagged.");

endmodule

/* common/fss_regs.svh */
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// Clock rate and time bases.
`define FSS_CLK_HZ 64'd20000000
`define FSS_MS_PER_S 64'd1000
`define FSS_US_PER_S 64'd1000000
`define FSS_MS_CYC (`FSS_CLK_HZ / `FSS_MS_PER_S)

// Least zero-mark width in microseconds, rounded up to whole cycles.
`define FSS_ZMARK_MIN_US 64'd400
`define FSS_ZMARK_CYC ((`FSS_ZMARK_MIN_US * `FSS_CLK_HZ + \
  `FSS_US_PER_S - 64'd1) / `FSS_US_PER_S)

// Zero speed in r/min and its hysteresis.
`define FSS_ZSP_DEFAULT 16'h0032
`define FSS_ZSP_HYST 16'h0014

// Speed used to scale the deceleration time constant, in r/min.
`define FSS_RATED_SPEED 16'h0BB8

// Display codes.
`define FSS_WARN_CODE 8'hE6
`define FSS_STO_ERR_CODE 8'h63
`define FSS_NO_CODE 8'h00

// Monitor resolution.
`define FSS_MON_W 10

`endif

/* common/fss_pkg.sv */
package fss_pkg;

  typedef enum logic [2:0] {
    FSS_RUN      = 3'b000,
    FSS_DECEL    = 3'b001,
    FSS_ILK_REL  = 3'b010,
    FSS_DELAY    = 3'b011,
    FSS_BASE_OFF = 3'b100
  } fss_state_t;

  typedef enum logic [1:0] {
    FSS_MON_SPEED = 2'b00,
    FSS_MON_MODEL = 2'b01,
    FSS_MON_LIFT  = 2'b10,
    FSS_MON_STATE = 2'b11
  } fss_mon_sel_t;

endpackage

/* verilog/fss_quad_gen.sv */
`timescale 1ns/1ps
module fss_quad_gen (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Step request.
  input wire logic step_i,
  input wire logic ccw_i,
  input wire logic swap_i,
  // Phase outputs.
  output logic a_o,
  output logic b_o
);

  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic up;

  // Counting up makes A lead B by a quarter period.
  assign up = ccw_i ^ swap_i;

  always_comb begin
    phase_next = phase_reg;
    if (step_i) begin
      phase_next = up ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
      a_o <= 1'b0;
      b_o <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      a_o <= phase_next[0] ^ phase_next[1];
      b_o <= phase_next[1];
    end
  end

  AST_ONE_EDGE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !($changed(a_o) && $changed(b_o)))
    else $error("Both encoder phases changed together.");

  AST_PHASE_ORDER: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (step_i && up && !a_o && !b_o) |=> (a_o && !b_o))
    else $error("Phase A did not lead phase B.");

endmodule

/* verification/fss_motor_model.sv */
`timescale 1ns/1ps
module fss_motor_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Drive side.
  input wire logic base_on_i,
  input wire logic signed [15:0] model_speed_i,
  // Shaft feedback.
  output logic signed [15:0] speed_o,
  output logic [31:0] pos_o,
  output logic [19:0] rev_pos_o
);
  // The shaft takes the command one clock later. There is no load model.
  // Only the order and timing of the sequence are judged against it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_o <= 16'sh0000;
      pos_o <= 32'h00000000;
    end else begin
      speed_o <= base_on_i ? model_speed_i : 16'sh0000;
      if (speed_o > 16'sh0000) pos_o <= pos_o + 32'h00000001;
    end
  end
  // Sixteen counts make one turn, so zero marks come every 16 cycles.
  assign rev_pos_o = {16'h0000, pos_o[3:0]};
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
  end \
end
module tb_top;
  import fss_pkg::*;
  localparam int MS = 20;
  localparam int ZM = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic em = 1'b1, safe_torque_off_input = 1'b1, alm = 1'b0, dbn = 1'b0, net = 1'b0;
  logic arst = 1'b0, tqm = 1'b0, phs = 1'b0, zld = 1'b0;
  logic signed [15:0] cmd = 16'sh0064;
  logic [15:0] tc = 16'h001E, dly = 16'h0002, comp = 16'h0000;
  logic [15:0] thr = 16'h0032, pls = 16'h0001, rat = 16'h0001;
  logic [9:0] m1, m2;
  logic [1:0] ms1 = 2'h0, ms2 = 2'h1;
  logic signed [15:0] spd, mdl;
  logic [31:0] pos;
  logic [19:0] rev;
  logic a, an, b, bn, z, zn, brk, base, dbk, err, zero_speed_flag;
  logic [15:0] lift;
  logic [7:0] disp;
  logic [2:0] st;
  int mismatches = 0;
  int checks = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  fss_motor_model i_fss_motor_model (.clk_i(clk), .rst_i(rst),
    .base_on_i(base), .model_speed_i(mdl), .speed_o(spd), .pos_o(pos),
    .rev_pos_o(rev));

  fss_top #(.MS_CYC(MS), .ZMARK_CYC(ZM)) i_fss_top (.SYS_CLK_I(clk),
    .SRST_I(rst), .FORCED_STOP_INPUT_I(em), .SAFE_TORQUE_OFF_INPUT_I(safe_torque_off_input),
    .ALARM_I(alm), .ALARM_DB_NOW_I(dbn), .NET_SHUTOFF_I(net),
    .ALARM_RESET_I(arst), .TORQUE_MODE_I(tqm), .MOTOR_SPEED_I(spd),
    .SPEED_CMD_I(cmd), .MOTOR_POS_I(pos), .REV_POS_I(rev),
    .ENCODER_OUTPUT_PULSE_SETTING_I(pls),
    .ENCODER_OUTPUT_RATIO_SETTING_I(rat),
    .ENCODER_PHASE_RELATION_SELECT_I(phs),
    .ZERO_SPEED_THRESHOLD_I(thr), .ZERO_SPEED_LOAD_I(zld),
    .STOP_DECEL_TIME_CONSTANT_I(tc), .BRAKE_TO_BASE_DELAY_PARAM_I(dly),
    .FREEFALL_COMP_AMOUNT_I(comp), .MONITOR_ONE_SELECT_I(ms1),
    .MONITOR_TWO_SELECT_I(ms2), .ENCODER_A_PHASE_OUT_O(a),
    .ENCODER_A_PHASE_OUT_INV_O(an), .ENCODER_B_PHASE_OUT_O(b),
    .ENCODER_B_PHASE_OUT_INV_O(bn), .ENCODER_ZERO_MARK_OUT_O(z),
    .ENCODER_ZERO_MARK_OUT_INV_O(zn), .ANALOG_MONITOR_ONE_O(m1),
    .ANALOG_MONITOR_TWO_O(m2), .BRAKE_INTERLOCK_OUT_O(brk), .BASE_ON_O(base),
    .DYNAMIC_BRAKE_O(dbk), .MODEL_SPEED_O(mdl), .FREEFALL_LIFT_O(lift),
    .DISPLAY_CODE_O(disp), .TORQUE_OFF_TIMING_ERROR_O(err),
    .ZERO_SPEED_FLAG_O(zero_speed_flag), .STOP_STATE_O(st));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_st(input logic [2:0] s, input int lim);
    int i;
    i = 0;
    while (st !== s && i < lim) begin
      @(negedge clk);
      i++;
    end
  endtask

  // Triggers are dropped together, and the pin settles before release.
  task automatic recover;
    @(posedge clk);
    {dbn, net, alm} <= 3'b000;
    em <= 1'b1;
    safe_torque_off_input <= 1'b1;
    arst <= 1'b1;
    wait_st(FSS_RUN, 20);
    @(posedge clk);
    arst <= 1'b0;
    @(negedge clk);
    `CHK("run again", FSS_RUN, st)
    `CHK("brake on", 1'b1, brk)
  endtask

  // Bits of tr: 0 pin stop, 1 alarm, 2 network loss, 3 instant brake.
  task automatic stop_seq(input logic [3:0] tr, input logic [2:0] first);
    int n;
    int d;
    n = 0;
    d = 0;
    @(posedge clk);
    {dbn, net, alm} <= tr[3:1];
    em <= ~tr[0];
    while (st === FSS_RUN && n < 10) begin
      @(negedge clk);
      n++;
    end
    `CHK("first state", first, st)
    `CHK("display", 8'hE6, disp)
    n = 0;
    while (st !== FSS_BASE_OFF && n < 3000) begin
      if (st === FSS_DELAY) begin
        if (d == 0) `CHK("lift", comp, lift)
        if (d == 0) `CHK("brake off", 1'b0, brk)
        d++;
      end
      @(negedge clk);
      n++;
    end
    `CHK("delay", first === FSS_BASE_OFF ? 0 : dly * MS, d)
    `CHK("base off", 1'b0, base)
    `CHK("dyn brake", 1'b1, dbk)
    recover();
  endtask

  task automatic enc(input logic sel, input logic [15:0] p,
    input logic [15:0] r);
    int n;
    logic pa;
    n = 0;
    @(posedge clk);
    phs <= sel;
    pls <= p;
    rat <= r;
    repeat (8) @(negedge clk);
    pa = a;
    @(negedge clk);
    while (!(pa === 1'b0 && a === 1'b1) && n < 100) begin
      pa = a;
      @(negedge clk);
      n++;
    end
    `CHK("a rise", 1'b1, a)
    `CHK("b at a rise", sel, b)
    `CHK("a inverse", ~a, an)
    `CHK("b inverse", ~b, bn)
    // One count a cycle gives p/r steps a cycle, four steps a period.
    n = 1;
    pa = a;
    @(negedge clk);
    while (!(pa === 1'b0 && a === 1'b1) && n < 100) begin
      pa = a;
      @(negedge clk);
      n++;
    end
    `CHK("a period", 4 * r / p, n)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end

  initial begin
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK("reset state", FSS_RUN, st)
    `CHK("reset base", 1'b1, base)
    `CHK("reset display", 8'h00, disp)
    $display("test reset done");
    // Creep of 100 r/min keeps at most one step per edge.
    enc(1'b0, 16'h0001, 16'h0001);
    enc(1'b1, 16'h0001, 16'h0001);
    enc(1'b0, 16'h0003, 16'h0006);
    `CHK("monitor one", 10'h201, m1)
    `CHK("monitor two", 10'h201, m2)
    $display("test encoder done");
    n = 0;
    while (z !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (z !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (z === 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK("zmark width", ZM, n)
    `CHK("zmark inverse", ~z, zn)
    n = 0;
    while (z === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK("zmark gap", 16 - ZM, n)
    $display("test zero mark done");
    // Each stop is a deliberate event, never a routine stop and go.
    stop_seq(4'b0001, FSS_DECEL);
    stop_seq(4'b0010, FSS_DECEL);
    stop_seq(4'b0100, FSS_DECEL);
    stop_seq(4'b1000, FSS_BASE_OFF);
    tqm <= 1'b1;
    stop_seq(4'b0001, FSS_ILK_REL);
    tqm <= 1'b0;
    $display("test triggers done");
    @(posedge clk);
    thr <= 16'h0064;
    zld <= 1'b1;
    @(posedge clk);
    zld <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("zsp loaded", 1'b1, zero_speed_flag)
    @(posedge clk);
    thr <= 16'h0032;
    zld <= 1'b1;
    @(posedge clk);
    zld <= 1'b0;
    cmd <= 16'sh0000;
    comp <= 16'h0005;
    repeat (10) @(negedge clk);
    `CHK("zero speed", 1'b1, zero_speed_flag)
    stop_seq(4'b0001, FSS_DECEL);
    comp <= 16'h0000;
    cmd <= 16'sh0064;
    $display("test freefall done");
    tc <= 16'h0BB8;
    repeat (10) @(negedge clk);
    @(posedge clk);
    em <= 1'b0;
    wait_st(FSS_DECEL, 10);
    @(posedge clk);
    safe_torque_off_input <= 1'b0;
    repeat (6) @(negedge clk);
    `CHK("sto error", 1'b1, err)
    `CHK("sto display", 8'h63, disp)
    // A 3000 ms constant takes 1 r/min off every millisecond.
    repeat (20) @(negedge clk);
    `CHK("ramp", 16'sh0063, mdl)
    @(posedge clk);
    dbn <= 1'b1;
    ms1 <= 2'h3;
    ms2 <= 2'h2;
    wait_st(FSS_BASE_OFF, 10);
    `CHK("db mid stop", FSS_BASE_OFF, st)
    @(negedge clk);
    `CHK("monitor state", 10'h200, m1)
    `CHK("monitor lift", 10'h000, m2)
    recover();
    $display("test torque off done");
    final_report();
  end
endmodule
